// ===== shared/bridge_option_pkg.sv
// ============================================================
// Bridge option register package
// ============================================================
// Purpose: Offsets, fields, reset values and carriers of the
//          bridge option register bank.
// Assumes: Configuration offsets are byte addresses of dwords.
// Notes:   Field positions are bit numbers in the 32-bit dword.
package bridge_option_pkg;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] OFS_ARB_PRIORITY = 8'h44;
  localparam logic [7:0] OFS_MEM_READ     = 8'h48;
  localparam logic [7:0] OFS_PREEMPT      = 8'h4c;
  localparam logic [7:0] OFS_EVENT_MASK   = 8'h64;
  localparam logic [7:0] OFS_ERR_STATUS   = 8'h68;

  // ==========================================================
  // Field positions and widths
  // ==========================================================
  localparam int ARB_GROUP_LSB  = 16;
  localparam int ARB_GROUP_W    = 4;
  localparam int ARB_SEC_BIT    = 25;
  localparam int MRD_DOWN_LSB   = 6;
  localparam int MRD_UP_LSB     = 4;
  localparam int MRD_FLUSH_BIT  = 0;
  localparam int PRE_CODE_LSB   = 28;
  localparam int PRE_CODE_W     = 4;
  localparam int MASK_LSB       = 1;
  localparam int STATUS_LSB     = 17;
  localparam int EVT_W          = 6;

  // Byte lanes owned by each register
  localparam int LANE_ARB_LO    = 2;
  localparam int LANE_ARB_HI    = 3;
  localparam int LANE_MRD       = 0;
  localparam int LANE_PRE       = 3;
  localparam int LANE_MASK      = 0;
  localparam int LANE_STATUS    = 2;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [3:0] ARB_GROUP_RST = 4'h0;
  localparam logic       ARB_SEC_RST   = 1'b1;
  localparam logic [1:0] PREFETCH_RST  = 2'h0;
  localparam logic       FLUSH_RST     = 1'b0;
  localparam logic [3:0] PRE_CODE_RST  = 4'h0;
  localparam logic [5:0] MASK_RST      = 6'h00;
  localparam logic [5:0] STATUS_RST    = 6'h00;

  // ==========================================================
  // Prefetch and preemption figures
  // ==========================================================
  localparam logic [6:0] PREFETCH_STEP_DW = 7'h10;   // 16 dwords a step
  localparam logic [6:0] PRE_CYC_3        = 7'h03;
  localparam logic [6:0] PRE_CYC_4        = 7'h04;
  localparam logic [6:0] PRE_CYC_8        = 7'h08;
  localparam logic [6:0] PRE_CYC_16       = 7'h10;
  localparam logic [6:0] PRE_CYC_32       = 7'h20;
  localparam logic [6:0] PRE_CYC_64       = 7'h40;
  localparam int         PRE_OFF_BIT      = 3;       // Top bit of code
  localparam int unsigned ATTEMPT_LIMIT_DEF = 32'h0100_0000; // 2^24

  // Event vector indices, bit n of mask is index n-1
  localparam int EV_PW_PARITY   = 0;
  localparam int EV_PW_NODELIV  = 1;
  localparam int EV_PW_TABORT   = 2;
  localparam int EV_PW_MABORT   = 3;
  localparam int EV_DW_NODELIV  = 4;
  localparam int EV_DR_NODATA   = 5;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic        wr;       // Configuration write strobe
    logic        rd;       // Configuration read strobe
    logic [7:0]  addr;     // Dword-aligned byte offset
    logic [3:0]  be_b;     // Byte enables, active low
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic pw_parity;       // Parity error delivering posted write
    logic pw_target_abort;
    logic pw_master_abort;
    logic pw_fail;         // Posted write attempt retried
    logic pw_ok;           // Posted write delivered
    logic dw_fail;         // Delayed write attempt retried
    logic dw_ok;
    logic dr_fail;         // Delayed read attempt returned no data
    logic dr_ok;
  } bridge_events_t;

  typedef enum logic [2:0] {
    PRE_IDLE    = 3'b001,
    PRE_COUNT   = 3'b010,
    PRE_ALLOWED = 3'b100
  } preempt_state_t;

endpackage

// ===== design/attempt_limit_counter.sv
// ============================================================
// Attempt limit counter
// ============================================================
// Purpose: Counts failed delivery attempts, gives up at a limit.
// Assumes: Fail and success pulses come from the same clock.
// Notes:   Give-up is a one-cycle registered pulse.
`timescale 1ns/10ps
module attempt_limit_counter
  import bridge_option_pkg::*;
#(
  parameter int unsigned LIMIT = ATTEMPT_LIMIT_DEF,
  parameter int          CNT_W = $clog2(LIMIT) + 1
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // Attempt results
  input  wire logic fail_in,
  input  wire logic ok_in,
  // Give up
  output logic      give_up_out
);

  // ==========================================================
  // Elaboration check
  // ==========================================================
  if (LIMIT < 2) begin : g_bad_limit
    $error("attempt limit must be at least two");
  end

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_give_up;

  // Next count, success or give-up restarts it
  always_comb begin
    next_count   = count;
    next_give_up = 1'b0;
    if (ok_in) begin
      next_count = '0;
    end else if (fail_in) begin
      if (count == LAST) begin
        next_count   = '0;
        next_give_up = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  // Register state
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count       <= '0;
      give_up_out <= 1'b0;
    end else begin
      count       <= next_count;
      give_up_out <= next_give_up;
    end
  end

endmodule

// ===== design/bridge_option_registers.sv
// ============================================================
// Bridge option registers
// ============================================================
// Purpose: Device-specific option registers of a PCI bridge and
//          the system error gating they steer.
// Assumes: Configuration strobes and events are on the PCI clock.
// Notes:   Read data is registered one cycle after the read.
//
// What this block does
// - Four group bits place secondary requesters by priority.
// - Own secondary interface priority bit, resets high.
// - Downstream prefetch cap 16, 32, 48, 64 dwords.
// - Upstream prefetch cap, same codes, resets 16.
// - Flush set: posted write discards read completions.
// - Flush clear: keep completions, normal ordering.
// - Preemption delay code; top bit disables preemption.
// - Codes 0-2 give 3 cycles, 3 gives 4.
// - Codes 4-7 give 8, 16, 32, 64 cycles.
// - Mask bit blocks error output; else needs enable.
// - Mask for posted write parity error.
// - Posted write undeliverable after limit; own mask.
// - Mask for target abort on posted write.
// - Mask for master abort on posted write.
// - Delayed write abandoned after limit; own mask.
// - Delayed read abandoned after limit; own mask.
// - Reserved bits read zero, ignore writes.
// - Error assertion records cause; write one clears.
`timescale 1ns/10ps
module bridge_option_registers
  import bridge_option_pkg::*;
#(
  parameter int unsigned ATTEMPT_LIMIT = ATTEMPT_LIMIT_DEF
) (
  // Clock and reset
  input  wire logic           clk_sys_in,
  input  wire logic           rst_b_in,
  // Configuration access
  input  wire cfg_req_t       cfg_req_in,
  output logic [31:0]         cfg_rdata_out,
  // Bridge events and command register enable
  input  wire bridge_events_t events_in,
  input  wire logic           serr_enable_in,
  input  wire logic           posted_write_rx_in,
  input  wire logic           frame_active_in,
  // Arbiter controls
  output logic [3:0]          arb_high_group_out,
  output logic                arb_secondary_high_out,
  output logic                preempt_allowed_out,
  // Prefetch and flush controls
  output logic [6:0]          down_prefetch_dw_out,
  output logic [6:0]          up_prefetch_dw_out,
  output logic                flush_completions_out,
  output logic                keep_ordering_out,
  // Give-up pulses and system error
  output logic [2:0]          discard_out,
  output logic                primary_system_error_out
);

  // ==========================================================
  // Register state
  // ==========================================================
  logic [3:0]  arb_group, next_arb_group;
  logic        arb_sec, next_arb_sec;
  logic [1:0]  pf_down, next_pf_down;
  logic [1:0]  pf_up, next_pf_up;
  logic        flush, next_flush;
  logic [3:0]  pre_code, next_pre_code;
  logic [5:0]  event_mask, next_event_mask;
  logic [5:0]  err_status, next_err_status;
  logic [31:0] next_rdata;
  logic [3:0]  lane_we;
  logic        hit_arb, hit_mrd, hit_pre, hit_mask, hit_stat;

  // Address decode on dword offset
  always_comb begin
    hit_arb  = cfg_req_in.addr[7:2] == OFS_ARB_PRIORITY[7:2];
    hit_mrd  = cfg_req_in.addr[7:2] == OFS_MEM_READ[7:2];
    hit_pre  = cfg_req_in.addr[7:2] == OFS_PREEMPT[7:2];
    hit_mask = cfg_req_in.addr[7:2] == OFS_EVENT_MASK[7:2];
    hit_stat = cfg_req_in.addr[7:2] == OFS_ERR_STATUS[7:2];
  end

  // Per-lane write enables from active-low byte enables
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign lane_we[gl] = cfg_req_in.wr & ~cfg_req_in.be_b[gl];
    end
  endgenerate

  // ==========================================================
  // Give-up counters for posted and delayed transactions
  // ==========================================================
  logic [2:0] try_fail;
  logic [2:0] try_ok;
  logic [2:0] give_up;

  assign try_fail = {events_in.dr_fail, events_in.dw_fail,
                     events_in.pw_fail};
  assign try_ok   = {events_in.dr_ok, events_in.dw_ok, events_in.pw_ok};

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_limit
      attempt_limit_counter #(
        .LIMIT (ATTEMPT_LIMIT)
      ) u_limit (
        .clk_sys_in  (clk_sys_in),
        .rst_b_in    (rst_b_in),
        .fail_in     (try_fail[gc]),
        .ok_in       (try_ok[gc]),
        .give_up_out (give_up[gc])
      );
    end
  endgenerate

  // ==========================================================
  // System error gating
  // ==========================================================
  logic [5:0] raw_event;
  logic [5:0] serr_cause;
  logic       next_serr;

  // Events arranged as mask bits 1 to 6
  always_comb begin
    raw_event                = '0;
    raw_event[EV_PW_PARITY]  = events_in.pw_parity;
    raw_event[EV_PW_NODELIV] = give_up[0];
    raw_event[EV_PW_TABORT]  = events_in.pw_target_abort;
    raw_event[EV_PW_MABORT]  = events_in.pw_master_abort;
    raw_event[EV_DW_NODELIV] = give_up[1];
    raw_event[EV_DR_NODATA]  = give_up[2];
    serr_cause = serr_enable_in ? (raw_event & ~event_mask) : '0;
    next_serr  = |serr_cause;
  end

  // ==========================================================
  // Register writes
  // ==========================================================
  always_comb begin
    next_arb_group  = arb_group;
    next_arb_sec    = arb_sec;
    next_pf_down    = pf_down;
    next_pf_up      = pf_up;
    next_flush      = flush;
    next_pre_code   = pre_code;
    next_event_mask = event_mask;
    next_err_status = err_status;
    if (hit_arb && lane_we[LANE_ARB_LO]) begin
      next_arb_group = cfg_req_in.wdata[ARB_GROUP_LSB +: ARB_GROUP_W];
    end
    if (hit_arb && lane_we[LANE_ARB_HI]) begin
      next_arb_sec = cfg_req_in.wdata[ARB_SEC_BIT];
    end
    if (hit_mrd && lane_we[LANE_MRD]) begin
      next_pf_down = cfg_req_in.wdata[MRD_DOWN_LSB +: 2];
      next_pf_up   = cfg_req_in.wdata[MRD_UP_LSB +: 2];
      next_flush   = cfg_req_in.wdata[MRD_FLUSH_BIT];
    end
    if (hit_pre && lane_we[LANE_PRE]) begin
      next_pre_code = cfg_req_in.wdata[PRE_CODE_LSB +: PRE_CODE_W];
    end
    if (hit_mask && lane_we[LANE_MASK]) begin
      next_event_mask = cfg_req_in.wdata[MASK_LSB +: EVT_W];
    end
    // Write one clears, a new cause in the same cycle wins
    if (hit_stat && lane_we[LANE_STATUS]) begin
      next_err_status = err_status &
                        ~cfg_req_in.wdata[STATUS_LSB +: EVT_W];
    end
    next_err_status = next_err_status | serr_cause;
  end

  // Read mux, unlisted bits stay zero
  always_comb begin
    next_rdata = cfg_rdata_out;
    if (cfg_req_in.rd) begin
      next_rdata = '0;
      if (hit_arb) begin
        next_rdata[ARB_GROUP_LSB +: ARB_GROUP_W] = arb_group;
        next_rdata[ARB_SEC_BIT]                  = arb_sec;
      end else if (hit_mrd) begin
        next_rdata[MRD_DOWN_LSB +: 2] = pf_down;
        next_rdata[MRD_UP_LSB +: 2]   = pf_up;
        next_rdata[MRD_FLUSH_BIT]     = flush;
      end else if (hit_pre) begin
        next_rdata[PRE_CODE_LSB +: PRE_CODE_W] = pre_code;
      end else if (hit_mask) begin
        next_rdata[MASK_LSB +: EVT_W] = event_mask;
      end else if (hit_stat) begin
        next_rdata[STATUS_LSB +: EVT_W] = err_status;
      end
    end
  end

  // Register bank flip-flops
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arb_group     <= ARB_GROUP_RST;
      arb_sec       <= ARB_SEC_RST;
      pf_down       <= PREFETCH_RST;
      pf_up         <= PREFETCH_RST;
      flush         <= FLUSH_RST;
      pre_code      <= PRE_CODE_RST;
      event_mask    <= MASK_RST;
      err_status    <= STATUS_RST;
      cfg_rdata_out <= '0;
    end else begin
      arb_group     <= next_arb_group;
      arb_sec       <= next_arb_sec;
      pf_down       <= next_pf_down;
      pf_up         <= next_pf_up;
      flush         <= next_flush;
      pre_code      <= next_pre_code;
      event_mask    <= next_event_mask;
      err_status    <= next_err_status;
      cfg_rdata_out <= next_rdata;
    end
  end

  // ==========================================================
  // Preemption timer
  // ==========================================================
  preempt_state_t pre_state, next_pre_state;
  logic [6:0]     pre_count, next_pre_count;
  logic [6:0]     pre_limit;
  logic           pre_off;

  // Decode delay code to cycles
  always_comb begin
    pre_off = pre_code[PRE_OFF_BIT];
    case (pre_code[2:0])
      3'h3:    pre_limit = PRE_CYC_4;
      3'h4:    pre_limit = PRE_CYC_8;
      3'h5:    pre_limit = PRE_CYC_16;
      3'h6:    pre_limit = PRE_CYC_32;
      3'h7:    pre_limit = PRE_CYC_64;
      default: pre_limit = PRE_CYC_3;
    endcase
  end

  // Count cycles since frame assertion
  always_comb begin
    next_pre_state = pre_state;
    next_pre_count = pre_count;
    case (pre_state)
      PRE_IDLE: begin
        next_pre_count = '0;
        if (frame_active_in) begin
          next_pre_state = PRE_COUNT;
          next_pre_count = 7'h01;
        end
      end
      PRE_COUNT: begin
        if (!frame_active_in) begin
          next_pre_state = PRE_IDLE;
        end else if (pre_count >= pre_limit - 7'h01) begin
          next_pre_state = PRE_ALLOWED;
        end else begin
          next_pre_count = pre_count + 7'h01;
        end
      end
      PRE_ALLOWED: begin
        if (!frame_active_in) begin
          next_pre_state = PRE_IDLE;
        end
      end
      default: next_pre_state = PRE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_state <= PRE_IDLE;
      pre_count <= '0;
    end else begin
      pre_state <= next_pre_state;
      pre_count <= next_pre_count;
    end
  end

  // ==========================================================
  // Registered control outputs
  // ==========================================================
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arb_high_group_out       <= ARB_GROUP_RST;
      arb_secondary_high_out   <= ARB_SEC_RST;
      preempt_allowed_out      <= 1'b0;
      down_prefetch_dw_out     <= PREFETCH_STEP_DW;
      up_prefetch_dw_out       <= PREFETCH_STEP_DW;
      flush_completions_out    <= 1'b0;
      keep_ordering_out        <= 1'b1;
      discard_out              <= '0;
      primary_system_error_out <= 1'b0;
    end else begin
      arb_high_group_out       <= arb_group;
      arb_secondary_high_out   <= arb_sec;
      preempt_allowed_out      <= !pre_off &&
                                  next_pre_state == PRE_ALLOWED;
      down_prefetch_dw_out     <= PREFETCH_STEP_DW *
                                  (7'(pf_down) + 7'h01);
      up_prefetch_dw_out       <= PREFETCH_STEP_DW *
                                  (7'(pf_up) + 7'h01);
      flush_completions_out    <= flush & posted_write_rx_in;
      keep_ordering_out        <= ~flush;
      discard_out              <= give_up;
      primary_system_error_out <= next_serr;
    end
  end

endmodule

// ===== verification/bridge_option_props.sv
// ============================================================
// Bridge option register checker
// ============================================================
// Purpose: Port-level assertions on the option register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound into the design from the testbench top.
`timescale 1ns/10ps
module bridge_option_props
  import bridge_option_pkg::*;
#(
  parameter int unsigned ATTEMPT_LIMIT = 4
) (
  // Clock and reset
  input wire logic           clk_sys_in,
  input wire logic           rst_b_in,
  // Watched ports
  input wire cfg_req_t       cfg_req_in,
  input wire logic [31:0]    cfg_rdata_out,
  input wire bridge_events_t events_in,
  input wire logic           serr_enable_in,
  input wire logic           posted_write_rx_in,
  input wire logic           frame_active_in,
  input wire logic [3:0]     arb_high_group_out,
  input wire logic           arb_secondary_high_out,
  input wire logic           preempt_allowed_out,
  input wire logic [6:0]     down_prefetch_dw_out,
  input wire logic [6:0]     up_prefetch_dw_out,
  input wire logic           keep_ordering_out,
  input wire logic           flush_completions_out,
  input wire logic [2:0]     discard_out,
  input wire logic           primary_system_error_out
);
  // Event groups
  wire logic       direct_ev = events_in.pw_parity |
                               events_in.pw_target_abort |
                               events_in.pw_master_abort;
  wire logic [2:0] fail_v = {events_in.dr_fail, events_in.dw_fail,
                             events_in.pw_fail};
  wire logic       fail_ev = |fail_v;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  a_reset_values: assert property ($rose(rst_b_in) |->
    arb_secondary_high_out && keep_ordering_out &&
    down_prefetch_dw_out == 7'h10 && up_prefetch_dw_out == 7'h10)
    else $error("control outputs wrong after reset");
  a_prefetch_legal: assert property (
    {down_prefetch_dw_out[3:0], up_prefetch_dw_out[3:0]} == 8'h00 &&
    down_prefetch_dw_out inside {[7'h10:7'h40]} &&
    up_prefetch_dw_out inside {[7'h10:7'h40]})
    else $error("prefetch count outside the four steps");
  a_ctrl_by_write: assert property ($changed({arb_high_group_out,
    arb_secondary_high_out, down_prefetch_dw_out, up_prefetch_dw_out,
    keep_ordering_out}) |-> $past(cfg_req_in.wr, 2))
    else $error("control output moved without a write");
  a_rdata_by_read: assert property ($changed(cfg_rdata_out) |->
    $past(cfg_req_in.rd) || $past(cfg_req_in.rd, 2))
    else $error("read data moved without a read");
  a_flush_cause: assert property (flush_completions_out |->
    $past(posted_write_rx_in) && !keep_ordering_out)
    else $error("flush pulse without posted write");
  a_preempt_drop: assert property (!frame_active_in |=>
    !preempt_allowed_out)
    else $error("preemption allowed with frame idle");
  a_preempt_min: assert property ($rose(frame_active_in) |->
    !preempt_allowed_out [*3])
    else $error("preemption allowed too early");
  a_discard_cause: assert property (|discard_out |->
    (discard_out & ~$past(fail_v, 2)) == 3'h0)
    else $error("discard without a failed attempt");
  a_serr_needs_en: assert property (primary_system_error_out |->
    $past(serr_enable_in))
    else $error("system error with enable clear");
  a_serr_cause: assert property (primary_system_error_out |->
    $past(direct_ev) || $past(fail_ev, 2))
    else $error("system error without a cause");
endmodule

// ===== verification/cfg_host_model.sv
// ============================================================
// Configuration host model
// ============================================================
// Purpose: Primary host issuing configuration reads and writes.
// Assumes: One-cycle strobes taken at the rising edge.
// Notes:   Idle fields show the inverse of the last request.
`timescale 1ns/10ps
module cfg_host_model
  import bridge_option_pkg::*;
(
  // Clock
  input  wire logic        clk_sys_in,
  // Configuration access
  input  wire logic [31:0] rdata_in,
  output cfg_req_t         cfg_req_out
);
  // Quiet bus at time zero
  initial cfg_req_out = '0;

  // One write strobe, then idle with inverted fields
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] d);
    @(posedge clk_sys_in);
    cfg_req_out <= '{1'b1, 1'b0, a, be, d};
    @(posedge clk_sys_in);
    cfg_req_out <= '{1'b0, 1'b0, ~a, ~be, ~d};
  endtask

  // One read strobe, data taken once it stands
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    cfg_req_out <= '{1'b0, 1'b1, a, 4'h0, 32'h0};
    @(posedge clk_sys_in);
    cfg_req_out <= '{1'b0, 1'b0, ~a, 4'hf, 32'hffff_ffff};
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    d = rdata_in;
  endtask
endmodule

// ===== verification/tb_bridge_option_registers.sv
// ============================================================
// Bridge option register testbench
// ============================================================
// Purpose: Register, prefetch, preemption and error tests.
// Assumes: Attempt limit shortened to 4 for the run.
// Notes:   Bus cycles come from the host model tasks.
`timescale 1ns/10ps
module tb_bridge_option_registers;
  import bridge_option_pkg::*;
  localparam int unsigned LIMIT = 4;
  logic           clk_sys_in, rst_b_in;
  cfg_req_t       cfg_req_in;
  logic [31:0]    cfg_rdata_out, rd;
  bridge_events_t events_in;
  logic           serr_enable_in, posted_write_rx_in, frame_active_in;
  logic [3:0]     arb_high_group_out, code;
  logic           arb_secondary_high_out, preempt_allowed_out;
  logic           flush_completions_out, keep_ordering_out;
  logic           primary_system_error_out;
  logic [6:0]     down_prefetch_dw_out, up_prefetch_dw_out;
  logic [2:0]     discard_out, seen;
  int             fails, compares, n, hits;
  int             delays[8] = '{3, 3, 3, 4, 8, 16, 32, 64};
  int             ev_pos[6] = '{8, 5, 7, 6, 3, 1};

  // Design and host
  bridge_option_registers #(.ATTEMPT_LIMIT(LIMIT)) i_bridge_option_registers (
    .clk_sys_in, .rst_b_in, .cfg_req_in, .cfg_rdata_out, .events_in,
    .serr_enable_in, .posted_write_rx_in, .frame_active_in,
    .arb_high_group_out, .arb_secondary_high_out, .preempt_allowed_out,
    .down_prefetch_dw_out, .up_prefetch_dw_out, .flush_completions_out,
    .keep_ordering_out, .discard_out, .primary_system_error_out);
  cfg_host_model i_cfg_host_model (.clk_sys_in, .rdata_in(cfg_rdata_out),
    .cfg_req_out(cfg_req_in));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    i_cfg_host_model.cfg_write(a, be, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    i_cfg_host_model.cfg_read(a, rd);
    chk(rd, exp);
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    stop_test();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    {rst_b_in, serr_enable_in, posted_write_rx_in, frame_active_in} = '0;
    {fails, compares} = '0;
    events_in = '0;
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd_chk(OFS_ARB_PRIORITY, 32'h0200_0000);
    rd_chk(OFS_MEM_READ, 32'h0);
    rd_chk(OFS_PREEMPT, 32'h0);
    chk(32'({down_prefetch_dw_out, keep_ordering_out}), 32'h21);
    $display("test reset done");
    wr(OFS_ARB_PRIORITY, 4'h0, 32'hffff_ffff);
    rd_chk(OFS_ARB_PRIORITY, 32'h020f_0000);
    wr(OFS_ARB_PRIORITY, 4'hb, 32'h0);
    rd_chk(OFS_ARB_PRIORITY, 32'h0200_0000);
    wr(OFS_ARB_PRIORITY, 4'h0, 32'h0005_0000);
    wr(OFS_ARB_PRIORITY, 4'h7, 32'h0);
    rd_chk(OFS_ARB_PRIORITY, 32'h0005_0000);
    chk(32'({arb_high_group_out, arb_secondary_high_out}), 32'ha);
    wr(8'h50, 4'h0, 32'hffff_ffff);
    rd_chk(8'h50, 32'h0);
    $display("test arbiter done");
    for (int c = 0; c < 4; c++) begin
      wr(OFS_MEM_READ, 4'h0, 32'({2'(c), 2'(3 - c), 4'he}));
      rd_chk(OFS_MEM_READ, 32'({2'(c), 2'(3 - c), 4'h0}));
      chk(32'({down_prefetch_dw_out, up_prefetch_dw_out}),
          32'({7'(16 * (c + 1)), 7'(16 * (4 - c))}));
    end
    for (int f = 1; f >= 0; f--) begin
      wr(OFS_MEM_READ, 4'he, 32'(f));
      @(posedge clk_sys_in);
      posted_write_rx_in <= 1'b1;
      @(posedge clk_sys_in);
      posted_write_rx_in <= 1'b0;
      @(negedge clk_sys_in);
      chk(32'({flush_completions_out, keep_ordering_out}),
          f ? 32'h2 : 32'h1);
    end
    $display("test prefetch done");
    for (int k = 0; k < 10; k++) begin
      code = (k < 9) ? 4'(k) : 4'hf;
      wr(OFS_PREEMPT, 4'h0, {code, 28'hfff_ffff});
      rd_chk(OFS_PREEMPT, {code, 28'h0});
      @(posedge clk_sys_in);
      frame_active_in <= 1'b1;
      n = 0;                                   // Cycle frame goes up
      @(negedge clk_sys_in);
      while (preempt_allowed_out !== 1'b1 && n < 80) begin
        @(negedge clk_sys_in);
        n++;
      end
      chk(32'(n), 32'(k < 8 ? delays[k] : 80));
      @(posedge clk_sys_in);
      frame_active_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
    end
    $display("test preemption done");
    wr(OFS_EVENT_MASK, 4'h0, 32'hffff_ffff);
    rd_chk(OFS_EVENT_MASK, 32'h7e);
    for (int k = 0; k < 6; k++) begin
      for (int m = 0; m < 3; m++) begin
        wr(OFS_EVENT_MASK, 4'he, (m == 1) ? 32'(2 << k) : 32'h0);
        @(posedge clk_sys_in);
        serr_enable_in <= (m != 2);
        events_in <= bridge_events_t'(9'h1 << ev_pos[k]);
        repeat ((k == 1 || k > 3) ? LIMIT : 1) @(posedge clk_sys_in);
        events_in <= '0;
        hits = 0;
        seen = '0;
        repeat (6) begin
          @(negedge clk_sys_in);
          hits += int'(primary_system_error_out);
          seen |= discard_out;
        end
        chk(32'(hits), 32'(m == 0));
        chk(32'(seen), k == 1 ? 32'h1 : k == 4 ? 32'h2 :
            k == 5 ? 32'h4 : 32'h0);
        rd_chk(OFS_ERR_STATUS, m == 0 ? 32'h1 << (17 + k) : 32'h0);
        wr(OFS_ERR_STATUS, 4'hb, 32'hffff_ffff);
      end
    end
    rd_chk(OFS_ERR_STATUS, 32'h0);
    $display("test system error done");
    stop_test();
  end
endmodule

// Checker on the design ports
bind bridge_option_registers bridge_option_props #(
  .ATTEMPT_LIMIT(ATTEMPT_LIMIT)) i_bridge_option_props (
  .clk_sys_in, .rst_b_in, .cfg_req_in, .cfg_rdata_out, .events_in,
  .serr_enable_in, .posted_write_rx_in, .frame_active_in,
  .arb_high_group_out, .arb_secondary_high_out, .preempt_allowed_out,
  .down_prefetch_dw_out, .up_prefetch_dw_out, .keep_ordering_out,
  .flush_completions_out, .discard_out, .primary_system_error_out);
